// ### core/tw_device_end.sv
// Summary of operation
// R1: One clock per bit; data stable while high
// R2: Conditions are data edges during clock high
// R3: Bus busy from START until STOP
// R4: Repeated START keeps the bus busy
// R5: Address packet: seven bits, direction, acknowledge
// R6: Direction one reads, zero writes
// R7: Matched slave pulls data low ninth clock
// R8: After address NACK: STOP or new START
// R9: Address sent most significant bit first
// R10: Address zero is general call, write only
// R11: Master never sends general call read
// R12: Addresses 1111xxx are reserved, never matched
// R13: Data packet: one byte plus acknowledge
// R14: Low in ninth clock ACKs, high NACKs
// R15: Last byte answered with NACK
// R16: Data byte sent most significant bit first
// R17: Only master clocks and makes conditions
// R18: START, address, data packets, then STOP
// R19: Slave may stretch clock low phase
// R20: Lines only pulled low or released
// R21: Power gate bit high keeps block disabled
// R22: Bus rates up to 400 kHz supported
// R23: Master losing arbitration releases data at once
// R24: START falls, STOP rises, clock high
`timescale 1ns/1ps
`default_nettype none

// *****
// Two-entry buffer
// *****
module byte_buffer #(
  parameter int WIDTH = twb_pkg::BYTE_W,
  parameter int DEPTH = twb_pkg::BUF_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [PW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = cnt_q != (PW + 1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + 1'h1;
      end
      if (pop)
      begin
        rd_q <= rd_q + 1'h1;
      end
      if (push && !pop)
      begin
        cnt_q <= cnt_q + 1'h1;
      end
      else if (pop && !push)
      begin
        cnt_q <= cnt_q - 1'h1;
      end
    end
  end
endmodule // byte_buffer

// *****
// Documented device end (slave)
// *****
module tw_device_end (
  input  wire logic                        clk,
  input  wire logic                        rst,
  two_wire_if.dev                          bus,
  input  wire logic                        serial_power_gate_bit,
  input  wire logic [twb_pkg::ADDR_W-1:0]  own_addr,
  input  wire logic                        gc_enable,
  input  wire logic                        nack_next,
  output logic [twb_pkg::BYTE_W-1:0]       rx_data,
  output logic                             rx_valid,
  input  wire logic                        rx_ready,
  input  wire logic [twb_pkg::BYTE_W-1:0]  tx_data,
  input  wire logic                        tx_valid,
  output logic                             tx_ready,
  output logic                             addressed,
  output logic                             gc_hit,
  output logic                             read_mode,
  output logic                             bus_busy,
  output logic                             stop_seen
);
  import twb_pkg::*;

  slave_state_t        state_q;
  logic [1:0]          scl_sync_q;
  logic [1:0]          sda_sync_q;
  logic                scl_p_q;
  logic                sda_p_q;
  logic [3:0]          cnt_q;
  logic [BYTE_W-1:0]   sh_q;
  logic                sda_low_q;
  logic                scl_low_q;
  logic                rw_q;
  logic                nack_q;
  logic                busy_q;
  logic                addressed_q;
  logic                gc_q;
  logic                stop_q;
  logic                scl_s;
  logic                sda_s;
  logic                scl_rise;
  logic                scl_fall;
  logic                start_ev;
  logic                stop_ev;
  logic [ADDR_W-1:0]   addr_in;
  logic                own_match;
  logic                gc_match;
  logic                addr_done;
  logic                rx_push;
  logic                rx_in_ready;
  logic                tx_pop;
  logic                tx_out_valid;
  logic [BYTE_W-1:0]   tx_out_data;

  // *****
  // Line sampling
  // *****
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      scl_sync_q <= SYNC_IDLE;
      sda_sync_q <= SYNC_IDLE;
      scl_p_q    <= 1'h1;
      sda_p_q    <= 1'h1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], bus.scl}; // R22
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      scl_p_q    <= scl_s;
      sda_p_q    <= sda_s;
    end
  end

  assign scl_s    = scl_sync_q[1];
  assign sda_s    = sda_sync_q[1];
  assign scl_rise = scl_s & ~scl_p_q; // R1
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_ev = start_cond(scl_p_q, scl_s, sda_p_q, sda_s); // R2 R24
  assign stop_ev  = stop_cond(scl_p_q, scl_s, sda_p_q, sda_s); // R2 R24

  // *****
  // Address match
  // *****
  assign addr_in   = sh_q[BYTE_W-1:1];
  assign addr_done = state_q == S_ADDR && scl_fall && cnt_q == BYTE_DONE; // R5
  assign own_match = addr_in == own_addr
                     && addr_in[ADDR_W-1:ADDR_W-4] != RSV_HIGH; // R12
  assign gc_match  = gc_enable && addr_in == GC_ADDR
                     && sh_q[0] != DIR_READ; // R10 R11

  // *****
  // Buffers
  // *****
  assign rx_push = state_q == S_RX_HOLD && rx_in_ready;
  assign tx_pop  = state_q == S_TX_LOAD && tx_out_valid;

  byte_buffer u_rx_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (rx_push),
    .in_ready  (rx_in_ready),
    .in_data   (sh_q),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  byte_buffer u_tx_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (tx_out_valid),
    .out_ready (tx_pop),
    .out_data  (tx_out_data)
  );

  // *****
  // Bus state
  // *****
  always_ff @(posedge clk)
  begin
    if (rst || serial_power_gate_bit) // R21
    begin
      busy_q <= 1'h0;
    end
    else if (start_ev)
    begin
      busy_q <= 1'h1; // R3 R4
    end
    else if (stop_ev)
    begin
      busy_q <= 1'h0; // R3
    end
  end

  // *****
  // Event pulses
  // *****
  always_ff @(posedge clk)
  begin
    if (rst || serial_power_gate_bit)
    begin
      addressed_q <= 1'h0;
      gc_q        <= 1'h0;
      stop_q      <= 1'h0;
    end
    else
    begin
      addressed_q <= addr_done && (own_match || gc_match);
      gc_q        <= addr_done && gc_match && !own_match;
      stop_q      <= stop_ev;
    end
  end

  // *****
  // Packet engine
  // *****
  always_ff @(posedge clk)
  begin
    if (rst || serial_power_gate_bit) // R21
    begin
      state_q   <= S_IDLE;
      cnt_q     <= CNT_ZERO;
      sh_q      <= '0;
      sda_low_q <= 1'h0;
      scl_low_q <= 1'h0;
      rw_q      <= 1'h0;
      nack_q    <= 1'h0;
    end
    else if (start_ev || stop_ev)
    begin
      state_q   <= start_ev ? S_ADDR : S_IDLE; // R4 R17
      cnt_q     <= CNT_ZERO;
      sda_low_q <= 1'h0;
      scl_low_q <= 1'h0;
    end
    else
    begin
      unique case (state_q)
        S_IDLE:
        begin
          sda_low_q <= 1'h0;
        end
        S_ADDR, S_RX:
        begin
          if (scl_rise)
          begin
            sh_q  <= {sh_q[BYTE_W-2:0], sda_s}; // R9 R16
            cnt_q <= cnt_q + 4'h1;
          end
          else if (scl_fall && cnt_q == BYTE_DONE) // R13
          begin
            if (state_q == S_RX)
            begin
              state_q   <= S_RX_HOLD;
              scl_low_q <= 1'h1; // R19
            end
            else if (own_match || gc_match)
            begin
              state_q   <= S_ADDR_ACK;
              sda_low_q <= 1'h1; // R7
              rw_q      <= sh_q[0];
            end
            else
            begin
              state_q <= S_IDLE; // R7 R8
            end
          end
        end
        S_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            sda_low_q <= 1'h0;
            cnt_q     <= CNT_ZERO;
            if (rw_q == DIR_READ) // R6
            begin
              state_q   <= S_TX_LOAD;
              scl_low_q <= 1'h1; // R19
            end
            else
            begin
              state_q <= S_RX;
            end
          end
        end
        S_RX_HOLD:
        begin
          if (rx_in_ready)
          begin
            sda_low_q <= ~nack_next; // R14 R15
            state_q   <= S_RX_ACK;
          end
        end
        S_RX_ACK:
        begin
          scl_low_q <= 1'h0; // R1 R19
          if (scl_fall)
          begin
            sda_low_q <= 1'h0;
            cnt_q     <= CNT_ZERO;
            state_q   <= S_RX;
          end
        end
        S_TX_LOAD:
        begin
          if (tx_out_valid)
          begin
            sh_q      <= tx_out_data;
            sda_low_q <= ~tx_out_data[BYTE_W-1]; // R16
            cnt_q     <= CNT_ZERO;
            state_q   <= S_TX;
          end
        end
        S_TX:
        begin
          scl_low_q <= 1'h0; // R1 R19
          if (scl_rise)
          begin
            cnt_q <= cnt_q + 4'h1;
          end
          else if (scl_fall)
          begin
            if (cnt_q == BYTE_DONE)
            begin
              sda_low_q <= 1'h0;
              state_q   <= S_TX_ACK;
            end
            else
            begin
              sh_q      <= {sh_q[BYTE_W-2:0], 1'h0};
              sda_low_q <= ~sh_q[BYTE_W-2]; // R1
            end
          end
        end
        S_TX_ACK:
        begin
          if (scl_rise)
          begin
            nack_q <= sda_s; // R14
          end
          else if (scl_fall)
          begin
            if (nack_q)
            begin
              state_q <= S_IDLE; // R15
            end
            else
            begin
              state_q   <= S_TX_LOAD;
              scl_low_q <= 1'h1; // R19
            end
          end
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // *****
  // Pins and status
  // *****
  assign bus.dev_scl_o  = 1'h0; // R20
  assign bus.dev_sda_o  = 1'h0; // R20
  assign bus.dev_scl_oe = scl_low_q;
  assign bus.dev_sda_oe = sda_low_q;
  assign addressed      = addressed_q;
  assign gc_hit         = gc_q;
  assign read_mode      = rw_q;
  assign bus_busy       = busy_q;
  assign stop_seen      = stop_q;
endmodule // tw_device_end

`default_nettype wire

// ### core/tw_host_end.sv
`timescale 1ns/1ps
`default_nettype none

// *****
// Far end (master)
// *****
module tw_host_end (
  input  wire logic                       clk,
  input  wire logic                       rst,
  two_wire_if.host                        bus,
  input  wire logic                       cmd_valid,
  output logic                            cmd_ready,
  input  wire twb_pkg::cmd_t              cmd,
  input  wire logic [twb_pkg::BYTE_W-1:0] cmd_data,
  input  wire logic                       cmd_nack,
  output logic                            res_valid,
  output logic [twb_pkg::BYTE_W-1:0]      res_data,
  output logic                            res_nack,
  output logic                            arb_lost,
  output logic                            bus_busy
);
  import twb_pkg::*;

  master_state_t     state_q;
  step_t             step_q;
  logic [1:0]        scl_sync_q;
  logic [1:0]        sda_sync_q;
  logic              scl_p_q;
  logic              sda_p_q;
  logic [TMR_W-1:0]  tmr_q;
  logic [3:0]        bit_q;
  logic [BYTE_W:0]   out_q;
  logic [BYTE_W:0]   in_q;
  logic              scl_low_q;
  logic              sda_low_q;
  logic              write_q;
  logic              first_q;
  logic              acked_q;
  logic              busy_q;
  logic              res_valid_q;
  logic              arb_q;
  logic [BYTE_W-1:0] res_data_q;
  logic              res_nack_q;
  logic              scl_s;
  logic              sda_s;
  logic              tick;
  logic              take;

  // *****
  // Line sampling and bus monitor
  // *****
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      scl_sync_q <= SYNC_IDLE;
      sda_sync_q <= SYNC_IDLE;
      scl_p_q    <= 1'h1;
      sda_p_q    <= 1'h1;
      busy_q     <= 1'h0;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], bus.scl};
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      scl_p_q    <= scl_s;
      sda_p_q    <= sda_s;
      if (start_cond(scl_p_q, scl_s, sda_p_q, sda_s)) // R2 R24
      begin
        busy_q <= 1'h1; // R3 R4
      end
      else if (stop_cond(scl_p_q, scl_s, sda_p_q, sda_s))
      begin
        busy_q <= 1'h0; // R3
      end
    end
  end

  assign scl_s     = scl_sync_q[1];
  assign sda_s     = sda_sync_q[1];
  assign tick      = tmr_q == TMR_ZERO;
  assign cmd_ready = (state_q == M_IDLE && !busy_q) || state_q == M_HOLD; // R3
  assign take      = cmd_valid && cmd_ready;

  // *****
  // Sequencer
  // *****
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q     <= M_IDLE;
      step_q      <= STEP_SETUP;
      tmr_q       <= TMR_ZERO;
      bit_q       <= CNT_ZERO;
      out_q       <= '0;
      in_q        <= '0;
      scl_low_q   <= 1'h0;
      sda_low_q   <= 1'h0;
      write_q     <= 1'h0;
      first_q     <= 1'h0;
      acked_q     <= 1'h0;
      res_valid_q <= 1'h0;
      arb_q       <= 1'h0;
      res_data_q  <= '0;
      res_nack_q  <= 1'h0;
    end
    else
    begin
      res_valid_q <= 1'h0;
      arb_q       <= 1'h0;
      if (!tick)
      begin
        tmr_q <= tmr_q - 1'h1;
      end
      unique case (state_q)
        M_IDLE, M_HOLD:
        begin
          step_q <= STEP_SETUP;
          tmr_q  <= QTR_LOAD;
          bit_q  <= CNT_ZERO;
          if (take)
          begin
            unique case (cmd)
              CMD_START:
              begin
                state_q <= M_START; // R4 R17
                first_q <= 1'h1;
                acked_q <= 1'h0;
              end
              CMD_WRITE:
              begin
                if (state_q == M_HOLD && (acked_q || (first_q
                    && cmd_data != {GC_ADDR, DIR_READ}))) // R8 R11
                begin
                  out_q   <= {cmd_data, 1'h1}; // R9 R16
                  write_q <= 1'h1;
                  state_q <= M_BYTE;
                end
              end
              CMD_READ:
              begin
                if (state_q == M_HOLD && acked_q) // R6
                begin
                  out_q   <= {8'hFF, cmd_nack}; // R14 R15
                  write_q <= 1'h0;
                  state_q <= M_BYTE;
                end
              end
              CMD_STOP:
              begin
                if (state_q == M_HOLD && !first_q) // R18
                begin
                  state_q <= M_STOP;
                end
              end
            endcase
          end
        end
        M_START, M_STOP, M_BYTE:
        begin
          unique case (step_q)
            STEP_SETUP:
            begin
              sda_low_q <= state_q == M_STOP
                           || (state_q == M_BYTE && !out_q[BYTE_W]); // R1
              if (tick)
              begin
                step_q <= STEP_RISE;
                tmr_q  <= QTR_LOAD;
              end
            end
            STEP_RISE:
            begin
              scl_low_q <= 1'h0;
              if (!scl_s)
              begin
                tmr_q <= QTR_LOAD; // R19
              end
              else if (tick && state_q == M_BYTE && write_q
                       && bit_q != BYTE_DONE && out_q[BYTE_W] && !sda_s)
              begin
                sda_low_q <= 1'h0; // R23
                state_q   <= M_IDLE;
                arb_q     <= 1'h1;
              end
              else if (tick)
              begin
                in_q      <= {in_q[BYTE_W-1:0], sda_s};
                sda_low_q <= state_q == M_START
                             || (state_q == M_BYTE && sda_low_q); // R24
                step_q    <= STEP_HIGH;
                tmr_q     <= QTR_LOAD;
              end
            end
            STEP_HIGH:
            begin
              if (tick && state_q == M_STOP)
              begin
                state_q <= M_IDLE;
              end
              else if (tick)
              begin
                scl_low_q <= 1'h1; // R17
                step_q    <= STEP_FALL;
                tmr_q     <= QTR_LOAD;
              end
            end
            STEP_FALL:
            begin
              if (tick && (state_q == M_START || bit_q == BYTE_DONE))
              begin
                state_q   <= M_HOLD;
                sda_low_q <= 1'h0;
                if (state_q == M_BYTE)
                begin
                  res_valid_q <= 1'h1; // R5 R13
                  res_data_q  <= in_q[BYTE_W:1];
                  res_nack_q  <= in_q[0];
                  acked_q     <= acked_q || !in_q[0];
                  first_q     <= 1'h0;
                end
              end
              else if (tick)
              begin
                bit_q  <= bit_q + 4'h1;
                out_q  <= {out_q[BYTE_W-1:0], 1'h1};
                step_q <= STEP_SETUP;
                tmr_q  <= QTR_LOAD;
              end
            end
          endcase
        end
        default:
        begin
          state_q <= M_IDLE;
        end
      endcase
    end
  end

  // *****
  // Pins and results
  // *****
  assign bus.host_scl_o  = 1'h0; // R20
  assign bus.host_sda_o  = 1'h0; // R20
  assign bus.host_scl_oe = scl_low_q;
  assign bus.host_sda_oe = sda_low_q;
  assign res_valid       = res_valid_q;
  assign res_data        = res_data_q;
  assign res_nack        = res_nack_q;
  assign arb_lost        = arb_q;
  assign bus_busy        = busy_q;
endmodule // tw_host_end

`default_nettype wire

// ### dv/test_two_wire_bus_framing.sv
`timescale 1ns/1ps
`default_nettype none

module test_two_wire_bus_framing;
  import twb_pkg::*;

  // ****
  // Signals
  // ****
  logic        clk = 1'b0, rst = 1'b1, serial_power_gate_bit = 1'b0;
  logic        gc_enable = 1'b0, nack_next = 1'b0, rx_ready = 1'b0;
  logic        tx_valid = 1'b0, cmd_valid = 1'b0, cmd_nack = 1'b0;
  logic        rx_valid, tx_ready, cmd_ready, res_valid, res_nack;
  logic        read_mode, dev_busy, host_busy, stretch, got_n;
  logic        adr_p, gc_p, stop_p;
  logic [2:0]  seen = 3'h0;
  logic [6:0]  own_addr = 7'h5A;
  logic [7:0]  rx_data, res_data, got_d, tx_data = 8'h00, cmd_data = 8'h00;
  cmd_t        cmd = CMD_START;
  int          err_count = 0, n_tests = 0;
  logic [17:0] tab [5] = '{{2'h2, 7'h5A, 8'hB4, 1'h1},
                           {2'h0, 7'h5A, 8'h66, 1'h1},
                           {2'h0, 7'h5A, 8'h00, 1'h1},
                           {2'h1, 7'h5A, 8'h00, 1'h0},
                           {2'h0, 7'h7A, 8'hF4, 1'h1}};

  initial
  begin
    forever #4 clk = ~clk;
  end

  // ****
  // Ends, link and checker
  // ****
  two_wire_if i_two_wire_if ();
  always_comb stretch = i_two_wire_if.dev_scl_oe;
  always @(posedge clk)
    seen <= cmd_valid ? 3'h0 : seen | {adr_p, gc_p, stop_p};

  tw_device_end i_tw_device_end (
    .clk(clk), .rst(rst), .bus(i_two_wire_if),
    .serial_power_gate_bit(serial_power_gate_bit), .own_addr(own_addr),
    .gc_enable(gc_enable), .nack_next(nack_next), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .addressed(adr_p),
    .gc_hit(gc_p), .read_mode(read_mode), .bus_busy(dev_busy),
    .stop_seen(stop_p)
  );

  tw_host_end i_tw_host_end (
    .clk(clk), .rst(rst), .bus(i_two_wire_if), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .cmd_data(cmd_data),
    .cmd_nack(cmd_nack), .res_valid(res_valid), .res_data(res_data),
    .res_nack(res_nack), .arb_lost(), .bus_busy(host_busy)
  );

  tw_link_chk i_tw_link_chk (
    .clk(clk), .rst(rst),
    .dev_scl_o(i_two_wire_if.dev_scl_o),
    .dev_scl_oe(i_two_wire_if.dev_scl_oe),
    .dev_sda_o(i_two_wire_if.dev_sda_o),
    .dev_sda_oe(i_two_wire_if.dev_sda_oe),
    .host_scl_o(i_two_wire_if.host_scl_o),
    .host_scl_oe(i_two_wire_if.host_scl_oe),
    .host_sda_o(i_two_wire_if.host_sda_o),
    .host_sda_oe(i_two_wire_if.host_sda_oe),
    .scl(i_two_wire_if.scl), .sda(i_two_wire_if.sda)
  );

  // ****
  // Tasks
  // ****
  task automatic end_sim();
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic wait_hi(ref logic s);
    int k;
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end while (s !== 1'b1 && k < 20000);
    if (k >= 20000)
    begin
      err_count++;
      end_sim();
    end
  endtask

  task automatic cmd_do(input cmd_t c, input logic [7:0] d, input logic n);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    cmd_data <= d;
    cmd_nack <= n;
    wait_hi(cmd_ready);
    @(posedge clk);
    cmd_valid <= 1'b0;
    if (c == CMD_WRITE || c == CMD_READ)
    begin
      wait_hi(res_valid);
      got_d = res_data;
      got_n = res_nack;
    end
  endtask

  task automatic rx_pop(input logic [7:0] e);
    @(posedge clk);
    rx_ready <= 1'b1;
    wait_hi(rx_valid);
    chk("rx_data", rx_data, e);
    @(posedge clk);
    rx_ready <= 1'b0;
  endtask

  task automatic tx_push(input logic [7:0] d);
    @(posedge clk);
    tx_valid <= 1'b1;
    tx_data <= d;
    wait_hi(tx_ready);
    @(posedge clk);
    tx_valid <= 1'b0;
  endtask

  // ****
  // Sequence
  // ****
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      {serial_power_gate_bit, gc_enable, own_addr} <= tab[i][17:9];
      cmd_do(CMD_START, 8'h00, 1'b0);
      cmd_do(CMD_WRITE, tab[i][8:1], 1'b0);
      chk("addr_nack", {7'h00, got_n}, {7'h00, tab[i][0]});
      chk("adr", {7'h00, seen[2]}, {7'h00, ~tab[i][0]});
      chk("gc", {7'h00, seen[1]}, {7'h00, tab[i][16] & ~tab[i][0]});
      cmd_do(CMD_STOP, 8'h00, 1'b0);
    end
    @(posedge clk);
    own_addr <= 7'h5A;
    cmd_do(CMD_START, 8'h00, 1'b0);
    fork
      begin
        cmd_do(CMD_WRITE, 8'hB4, 1'b0);
        chk("busy", {7'h00, dev_busy}, 8'h01);
        cmd_do(CMD_WRITE, 8'hA5, 1'b0);
        chk("echo", got_d, 8'hA5);
        cmd_do(CMD_WRITE, 8'h3C, 1'b0);
        cmd_do(CMD_WRITE, 8'h81, 1'b0);
        chk("ack", {7'h00, got_n}, 8'h00);
      end
      begin
        repeat (3) wait_hi(res_valid);
        wait_hi(stretch);
        repeat (200) @(posedge clk);
        rx_pop(8'hA5);
        rx_pop(8'h3C);
        rx_pop(8'h81);
      end
    join
    @(posedge clk);
    nack_next <= 1'b1;
    cmd_do(CMD_WRITE, 8'h96, 1'b0);
    chk("nack", {7'h00, got_n}, 8'h01);
    @(posedge clk);
    nack_next <= 1'b0;
    rx_pop(8'h96);
    tx_push(8'hC3);
    tx_push(8'h5E);
    cmd_do(CMD_START, 8'h00, 1'b0);
    cmd_do(CMD_WRITE, 8'hB5, 1'b0);
    chk("rd_ack", {7'h00, got_n}, 8'h00);
    chk("rd_mode", {7'h00, read_mode}, 8'h01);
    chk("rs_busy", {7'h00, dev_busy}, 8'h01);
    chk("h_busy", {7'h00, host_busy}, 8'h01);
    cmd_do(CMD_READ, 8'h00, 1'b0);
    chk("rd0", got_d, 8'hC3);
    cmd_do(CMD_READ, 8'h00, 1'b1);
    chk("rd1", got_d, 8'h5E);
    cmd_do(CMD_STOP, 8'h00, 1'b0);
    wait_hi(cmd_ready);
    repeat (8) @(negedge clk);
    chk("idle", {7'h00, dev_busy}, 8'h00);
    chk("stop", {7'h00, seen[0]}, 8'h01);
    end_sim();
  end
endmodule // test_two_wire_bus_framing

`default_nettype wire

// ### dv/tw_link_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ****
// Link checks
// ****
module tw_link_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_dev_pull_low: assert property
    (!dev_scl_o && !dev_sda_o)
    else $error("device drives high");
  chk_host_pull_low: assert property
    (!host_scl_o && !host_sda_o)
    else $error("host drives high");
  chk_stretch_start: assert property
    ($rose(dev_scl_oe) |-> !$past(scl))
    else $error("stretch not in low");
  chk_stretch_end: assert property
    ($fell(dev_scl_oe) |-> ##[0:200] scl)
    else $error("clock not resumed");
  chk_high_phase: assert property
    ($rose(scl) |-> scl [*8])
    else $error("short high phase");
  chk_data_hold: assert property
    (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("data moved in high");
  chk_ack_drive: assert property
    ($rose(dev_sda_oe) |-> !scl)
    else $error("ack drive in high");
  chk_slave_stop: assert property
    ($rose(sda) && scl |-> !$past(dev_sda_oe))
    else $error("slave made a stop");
endmodule // tw_link_chk

`default_nettype wire

// ### include/twb_pkg.sv
package twb_pkg;

  // *****
  // Framing constants
  // *****
  localparam int         BYTE_W      = 8;
  localparam int         ADDR_W      = 7;
  localparam logic [3:0] CNT_ZERO    = 4'h0;
  localparam logic [3:0] BYTE_DONE   = 4'h8;
  localparam int         BUF_DEPTH   = 2;
  localparam logic [6:0] GC_ADDR     = 7'h00;
  localparam logic [3:0] RSV_HIGH    = 4'hF;
  localparam logic       DIR_READ    = 1'h1;
  localparam logic [1:0] SYNC_IDLE   = 2'h3;

  // *****
  // Timing
  // *****
  localparam int         CLK_MHZ     = 125;
  localparam int         BUS_MAX_KHZ = 400;
  localparam int         QTR_CYC     =
    (CLK_MHZ * 1000 + 4 * BUS_MAX_KHZ - 1) / (4 * BUS_MAX_KHZ);
  localparam int         TMR_W       = 8;
  localparam logic [TMR_W-1:0] QTR_LOAD = TMR_W'(QTR_CYC);
  localparam logic [TMR_W-1:0] TMR_ZERO = '0;

  // *****
  // Types
  // *****
  typedef enum logic [3:0] {
    S_IDLE     = 4'h0,
    S_ADDR     = 4'h1,
    S_ADDR_ACK = 4'h3,
    S_RX       = 4'h2,
    S_RX_HOLD  = 4'h6,
    S_RX_ACK   = 4'h7,
    S_TX_LOAD  = 4'h5,
    S_TX       = 4'h4,
    S_TX_ACK   = 4'hC
  } slave_state_t;

  typedef enum logic [2:0] {
    M_IDLE  = 3'h0,
    M_START = 3'h1,
    M_HOLD  = 3'h3,
    M_BYTE  = 3'h2,
    M_STOP  = 3'h6
  } master_state_t;

  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_READ  = 2'h2,
    CMD_STOP  = 2'h3
  } cmd_t;

  typedef enum logic [1:0] {
    STEP_SETUP = 2'h0,
    STEP_RISE  = 2'h1,
    STEP_HIGH  = 2'h3,
    STEP_FALL  = 2'h2
  } step_t;

  // *****
  // Condition detection
  // *****
  function automatic logic start_cond(input logic scl_p, input logic scl_n,
                                      input logic sda_p, input logic sda_n);
    return scl_p & scl_n & sda_p & ~sda_n;
  endfunction

  function automatic logic stop_cond(input logic scl_p, input logic scl_n,
                                     input logic sda_p, input logic sda_n);
    return scl_p & scl_n & ~sda_p & sda_n;
  endfunction

endpackage

// ### include/two_wire_if.sv
`timescale 1ns/1ps
`default_nettype none

interface two_wire_if;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic scl;
  logic sda;

  // Wired-AND with pull-up
  assign scl = ~((dev_scl_oe & ~dev_scl_o) | (host_scl_oe & ~host_scl_o));
  assign sda = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o));

  modport dev  (output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe,
                input scl, sda);
  modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
                input scl, sda);
endinterface

`default_nettype wire
